// [logic/tefr_core.sv]
`timescale 1ns/10ps
`default_nettype none
`include "tefr_cfg.svh"
module tefr_core (
  input  wire logic                      ref_clk,
  input  wire logic                      arst_n,
  input  wire logic [7:0]                avs_address,
  input  wire logic                      avs_read,
  input  wire logic                      avs_write,
  input  wire logic [31:0]               avs_writedata,
  input  wire logic [3:0]                avs_byteenable,
  output logic      [31:0]               avs_readdata,
  output logic                           avs_waitrequest,
  input  wire logic                      cnt_wrap,
  input  wire logic                      trig_reinit,
  input  wire logic                      trig_edge,
  input  wire logic                      gate_change,
  input  wire logic                      slave_enabled,
  input  wire logic                      gated_mode,
  input  wire logic                      center_aligned,
  input  wire logic                      count_down,
  input  wire logic [15:0]               auto_reload_value,
  input  wire tefr_pkg::tefr_chan_t      chan_is_input,
  input  wire tefr_pkg::tefr_chan_t      chan_match,
  input  wire tefr_pkg::tefr_chan_t      chan_above_reload,
  input  wire tefr_pkg::tefr_chan_t      chan_capture,
  input  wire tefr_pkg::tefr_chan_t      chan_value_read,
  output tefr_pkg::tefr_chan_t           capture_load,
  output logic                           sw_update,
  output logic      [15:0]               reinit_value,
  output logic      [5:0]                dma_req,
  output logic                           irq_req
);

  // ---------------------------------------------------------------
  // bus slave
  // ---------------------------------------------------------------
  tefr_pkg::tefr_reg_t ctrl;
  tefr_pkg::tefr_reg_t dma_irq_enable;
  tefr_pkg::tefr_reg_t event_status_flags;
  tefr_pkg::tefr_reg_t next_status;
  tefr_pkg::tefr_reg_t event_generate;
  tefr_pkg::tefr_reg_t wmask;
  tefr_pkg::tefr_reg_t sr_clr;
  tefr_pkg::tefr_reg_t sr_set;
  logic                wr_go;
  logic                rd_go;

  function automatic tefr_pkg::tefr_reg_t be_mask(input logic [3:0] be);
    be_mask = {{8{be[1]}}, {8{be[0]}}};
  endfunction : be_mask

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  assign wr_go = avs_write & ~avs_waitrequest;
  assign rd_go = avs_read & ~avs_waitrequest;
  assign wmask = be_mask(avs_byteenable);

  // one wait state: keeps every bus output registered
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      avs_waitrequest <= 1'b1;
    end else if ((avs_read | avs_write) & avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      avs_readdata <= `TEFR_RD_ZERO;
    end else if (avs_read & avs_waitrequest) begin
      // generate register is write-only and reads zero
      if (hit(avs_address, `TEFR_OFF_CTRL)) begin
        avs_readdata <= {16'h0000, ctrl};
      end else if (hit(avs_address, `TEFR_OFF_DIER)) begin
        avs_readdata <= {16'h0000, dma_irq_enable};
      end else if (hit(avs_address, `TEFR_OFF_SR)) begin
        avs_readdata <= {16'h0000, event_status_flags};
      end else begin
        avs_readdata <= `TEFR_RD_ZERO;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl <= `TEFR_RST;
    end else if (wr_go & hit(avs_address, `TEFR_OFF_CTRL)) begin
      ctrl <= ((ctrl & ~wmask) | (avs_writedata[15:0] & wmask)) & `TEFR_CTRL_MASK;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      dma_irq_enable <= `TEFR_RST;
    end else if (wr_go & hit(avs_address, `TEFR_OFF_DIER)) begin
      dma_irq_enable <= ((dma_irq_enable & ~wmask) | (avs_writedata[15:0] & wmask)) & `TEFR_DIER_MASK;
    end
  end

  // ---------------------------------------------------------------
  // event generation
  // ---------------------------------------------------------------
  // a write of one lives exactly one cycle, so the bit never stays set
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      event_generate <= `TEFR_RST;
    end else if (wr_go & hit(avs_address, `TEFR_OFF_EGR)) begin
      event_generate <= avs_writedata[15:0] & wmask & `TEFR_EGR_MASK;
    end else begin
      event_generate <= `TEFR_RST;
    end
  end

  logic                 ug;
  logic                 tg;
  tefr_pkg::tefr_chan_t ccg;
  logic                 update_disable;
  logic                 update_request_source;
  logic                 chan_dma_select;
  logic                 upd_set;
  logic                 trg_set;
  tefr_pkg::tefr_chan_t cmp_set;
  tefr_pkg::tefr_chan_t cap_set;
  tefr_pkg::tefr_chan_t cc_set;
  tefr_pkg::tefr_chan_t ovc_set;
  tefr_pkg::tefr_chan_t cc_dma;

  assign ug   = event_generate[`TEFR_B_UPD];
  assign tg   = event_generate[`TEFR_B_TRG];
  assign ccg  = event_generate[`TEFR_B_CH_HI:`TEFR_B_CH_LO];
  assign update_disable = ctrl[`TEFR_B_UPDATE_DISABLE];
  assign update_request_source  = ctrl[`TEFR_B_URS];
  assign chan_dma_select = ctrl[`TEFR_B_CHAN_DMA_SELECT];

  // ---------------------------------------------------------------
  // flag sources
  // ---------------------------------------------------------------
  assign upd_set = ~update_disable & (cnt_wrap | (~update_request_source & (ug | trig_reinit)));
  assign trg_set = tg | (slave_enabled & (gated_mode ? gate_change : trig_edge));
  assign cmp_set = ~chan_is_input & (chan_match | ({4{cnt_wrap}} & chan_above_reload) | ccg);
  assign cap_set = chan_is_input & (chan_capture | ccg);
  assign cc_set  = cmp_set | cap_set;
  // capture on a still-set event flag; one vector covers all four channels
  assign ovc_set = cap_set & event_status_flags[`TEFR_B_CH_HI:`TEFR_B_CH_LO];

  always_comb begin
    sr_set = `TEFR_RST;
    sr_set[`TEFR_B_UPD] = upd_set;
    sr_set[`TEFR_B_TRG] = trg_set;
    sr_set[`TEFR_B_CH_HI:`TEFR_B_CH_LO] = cc_set;
    sr_set[`TEFR_B_OVC_HI:`TEFR_B_OVC_LO] = ovc_set;
    sr_clr = `TEFR_RST;
    if (wr_go & hit(avs_address, `TEFR_OFF_SR)) begin
      sr_clr = ~avs_writedata[15:0] & wmask;
    end
    // reading an input channel's value clears its event flag
    sr_clr[`TEFR_B_CH_HI:`TEFR_B_CH_LO] = sr_clr[`TEFR_B_CH_HI:`TEFR_B_CH_LO]
                                          | (chan_value_read & chan_is_input);
    next_status = ((event_status_flags & ~sr_clr) | sr_set) & `TEFR_SR_MASK;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      event_status_flags <= `TEFR_RST;
    end else begin
      event_status_flags <= next_status;
    end
  end

  // ---------------------------------------------------------------
  // requests and counter side effects
  // ---------------------------------------------------------------
  // the update event for channel DMA is the one that also sets the flag
  assign cc_dma = chan_dma_select ? {4{upd_set}} : cc_set;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      dma_req <= 6'h00;
    end else begin
      dma_req[0]   <= upd_set & dma_irq_enable[`TEFR_B_UDMA];
      dma_req[4:1] <= cc_dma & dma_irq_enable[`TEFR_B_CDMA_HI:`TEFR_B_CDMA_LO];
      dma_req[5]   <= trg_set & dma_irq_enable[`TEFR_B_TDMA];
    end
  end

  // level follows the flags, so it falls with the clearing write
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_req <= 1'b0;
    end else begin
      irq_req <= |(next_status[`TEFR_B_TRG:`TEFR_B_UPD] & dma_irq_enable[`TEFR_B_TRG:`TEFR_B_UPD]);
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      capture_load <= 4'h0;
    end else begin
      capture_load <= chan_is_input & ccg;
    end
  end

  // update_generate reloads even when update_disable hides the flag
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sw_update <= 1'b0;
    end else begin
      sw_update <= ug;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      reinit_value <= `TEFR_RST;
    end else if (center_aligned | ~count_down) begin
      reinit_value <= `TEFR_RST;
    end else begin
      reinit_value <= auto_reload_value;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  chk_irq_follow: assert property (
    ##1 irq_req == $past(|(next_status[6:0] & dma_irq_enable[6:0])))
    else $error("irq does not follow enabled flags");
  chk_irq_masked: assert property (
    (dma_irq_enable[6:0] == 7'h00) |=> !irq_req)
    else $error("irq raised with all enables off");
  chk_dma_gate: assert property (
    (trg_set && !dma_irq_enable[`TEFR_B_TDMA]) |=> !dma_req[5])
    else $error("trigger dma issued while disabled");
  chk_ovc_input: assert property (
    $rose(event_status_flags[9]) |-> $past(chan_is_input[0] && event_status_flags[1]))
    else $error("overcapture set without pending capture");
  chk_w0_clear: assert property (
    (wr_go && hit(avs_address, `TEFR_OFF_SR) && avs_byteenable[0]
     && !avs_writedata[6] && !trg_set) |=> !event_status_flags[6])
    else $error("zero write did not clear trigger flag");
  chk_set_wins: assert property (
    (wr_go && hit(avs_address, `TEFR_OFF_SR) && upd_set) |=> event_status_flags[0])
    else $error("clear beat a same-cycle set");
  chk_ug_flag: assert property (
    (wr_go && hit(avs_address, `TEFR_OFF_EGR) && avs_byteenable[0]
     && avs_writedata[0] && !update_disable && !update_request_source) |=> ##1 event_status_flags[0] && sw_update)
    else $error("update generate did not set flag");
  chk_egr_pulse: assert property (
    (event_generate != 16'h0000) |=> (event_generate == 16'h0000) || $past(wr_go))
    else $error("generate bit stayed set");
  chk_update_disable_block: assert property (
    (update_disable && !sr_set[0] && !(wr_go && hit(avs_address, `TEFR_OFF_SR)) && !event_status_flags[0])
    |=> !event_status_flags[0])
    else $error("update flag set while disabled");
  chk_reinit: assert property (
    (count_down && !center_aligned) |=> reinit_value == $past(auto_reload_value))
    else $error("down-count reload value wrong");

  // gated mode ignores plain edges; only start, stop and trigger generate count
  chk_trg_gated: assert property (
    (slave_enabled && gated_mode && trig_edge && !gate_change && !tg && !event_status_flags[6])
    |=> !event_status_flags[6])
    else $error("trigger edge set flag in gated mode");
  chk_cmp_match: assert property (
    (!chan_is_input[0] && chan_match[0]) |=> event_status_flags[1])
    else $error("compare match did not set flag");
  chk_read_clear: assert property (
    (chan_is_input[0] && chan_value_read[0] && !cap_set[0]) |=> !event_status_flags[1])
    else $error("value read did not clear flag");
  chk_tg_flag: assert property (
    tg |=> event_status_flags[6])
    else $error("trigger generate did not set flag");
  chk_out_gen: assert property (
    (ccg[0] && !chan_is_input[0]) |=> event_status_flags[1] && !capture_load[0])
    else $error("output channel generate wrong");
  chk_cap_load: assert property (
    (ccg[0] && chan_is_input[0]) |=> capture_load[0])
    else $error("input channel generate did not load");
  chk_chan_dma_select_sel: assert property (
    (chan_dma_select && !upd_set) |=> !dma_req[1])
    else $error("channel dma issued off the update event");

  cov_overcapture: cover property (chan_is_input[0] && chan_capture[0] && event_status_flags[1]);
  cov_sw_update: cover property (sw_update);
  cov_cmp_wrap: cover property (cnt_wrap && (chan_above_reload != 4'h0));
  cov_gated_trig: cover property (slave_enabled && gated_mode && gate_change);
  cov_chan_dma_select_dma: cover property (chan_dma_select && upd_set && dma_irq_enable[9]);

endmodule : tefr_core
`default_nettype wire

// [logic/tefr_cfg.svh]
`ifndef TEFR_CFG_SVH
`define TEFR_CFG_SVH
// ---------------------------------------------------------------
// register map (byte addresses)
// ---------------------------------------------------------------
`define TEFR_OFF_CTRL   8'h00
`define TEFR_OFF_DIER   8'h0c
`define TEFR_OFF_SR     8'h10
`define TEFR_OFF_EGR    8'h14
`define TEFR_RST        16'h0000
`define TEFR_RD_ZERO    32'h0000_0000
// ---------------------------------------------------------------
// valid bit masks
// ---------------------------------------------------------------
`define TEFR_CTRL_MASK  16'h000e
`define TEFR_DIER_MASK  16'h5f5f
`define TEFR_SR_MASK    16'h1e5f
`define TEFR_EGR_MASK   16'h005f
// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define TEFR_B_UPD      0
`define TEFR_B_CH_LO    1
`define TEFR_B_CH_HI    4
`define TEFR_B_TRG      6
`define TEFR_B_UDMA     8
`define TEFR_B_CDMA_LO  9
`define TEFR_B_CDMA_HI  12
`define TEFR_B_TDMA     14
`define TEFR_B_OVC_LO   9
`define TEFR_B_OVC_HI   12
`define TEFR_B_UPDATE_DISABLE     1
`define TEFR_B_URS      2
`define TEFR_B_CHAN_DMA_SELECT     3
`endif

// [logic/tefr_pkg.sv]
`default_nettype none
package tefr_pkg;
  typedef logic [15:0] tefr_reg_t;
  typedef logic [3:0]  tefr_chan_t;
endpackage : tefr_pkg
`default_nettype wire

// [bench/tefr_req_sink.sv]
`timescale 1ns/10ps
`default_nettype none
// interrupt and dma controller stand-in: counts every dma request pulse it sees and latches any irq
module tefr_req_sink (
  input  wire logic       ref_clk,
  input  wire logic       arst_n,
  input  wire logic [5:0] dma_req,
  input  wire logic       irq_req,
  output var int          dma_total,
  output logic            irq_seen
);
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      dma_total <= 0;
      irq_seen  <= 1'b0;
    end else begin
      dma_total <= dma_total + $countones(dma_req);
      irq_seen  <= irq_seen | irq_req;
    end
  end
endmodule : tefr_req_sink
`default_nettype wire

// [bench/timer_event_flags_requests_tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
module timer_event_flags_requests_tb_top;
  logic ref_clk, arst_n, avs_read, avs_write, avs_waitrequest, sw_update, irq_req, irq_seen;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic cnt_wrap, trig_reinit, trig_edge, gate_change, slave_enabled, gated_mode, count_down, center_aligned;
  tefr_pkg::tefr_chan_t chan_match, chan_above_reload;
  logic [15:0] auto_reload_value, reinit_value;
  tefr_pkg::tefr_chan_t chan_is_input, chan_capture, chan_value_read, capture_load;
  logic [5:0] dma_req;
  int dma_total, fail_count, n_compared, cycles, swu_n, cap_n;
  tefr_core tefr_core_inst (.ref_clk(ref_clk), .arst_n(arst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'h3), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .cnt_wrap(cnt_wrap), .trig_reinit(trig_reinit), .trig_edge(trig_edge), .gate_change(gate_change),
    .slave_enabled(slave_enabled), .gated_mode(gated_mode), .center_aligned(center_aligned),
    .count_down(count_down), .auto_reload_value(auto_reload_value), .chan_is_input(chan_is_input),
    .chan_match(chan_match), .chan_above_reload(chan_above_reload), .chan_capture(chan_capture),
    .chan_value_read(chan_value_read), .capture_load(capture_load), .sw_update(sw_update),
    .reinit_value(reinit_value), .dma_req(dma_req), .irq_req(irq_req));
  tefr_req_sink tefr_req_sink_inst (.ref_clk(ref_clk), .arst_n(arst_n), .dma_req(dma_req),
    .irq_req(irq_req), .dma_total(dma_total), .irq_seen(irq_seen));
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // ---------------------------------------------------------------
  // checks, bus cycles, event pulses
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk
  // request held until the edge that samples waitrequest low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    avs_address   <= a;
    avs_writedata <= {16'h0000, d};
    avs_write     <= wr;
    avs_read      <= !wr;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask : bus
  task automatic ev(input logic [3:0] s, input logic [3:0] cap, input logic [3:0] rdc);
    @(posedge ref_clk);
    {cnt_wrap, trig_reinit, trig_edge, gate_change} <= s;
    chan_capture    <= cap;
    chan_value_read <= rdc;
    @(posedge ref_clk);
    {cnt_wrap, trig_reinit, trig_edge, gate_change} <= 4'h0;
    chan_capture    <= 4'h0;
    chan_value_read <= 4'h0;
    repeat (2) @(posedge ref_clk);
  endtask : ev
  task automatic status_is(input logic [15:0] exp, input string what);
    bus(1'b0, 8'h10, 16'h0000);
    chk(rd, {16'h0000, exp}, what);
  endtask : status_is
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_regs();
    bus(1'b0, 8'h0c, 16'h0000);
    chk(rd, 32'h0000_0000, "enable reset");
    bus(1'b1, 8'h0c, 16'h5f5f);
    bus(1'b0, 8'h0c, 16'h0000);
    chk(rd, 32'h0000_5f5f, "enable readback");
    bus(1'b0, 8'h20, 16'h0000);
    chk(rd, 32'h0000_0000, "unmapped read");
    $display("test regs done");
  endtask : t_regs
  task automatic t_generate();
    int d0;
    d0 = dma_total;
    bus(1'b1, 8'h14, 16'h005f);
    status_is(16'h005f, "generate flags");
    chk(dma_total - d0, 6, "generate dma");
    chk({31'h0, irq_req}, 1, "generate irq");
    chk({31'h0, irq_seen}, 1, "irq seen by controller");
    chk(swu_n, 1, "sw update pulse");
    bus(1'b0, 8'h14, 16'h0000);
    chk(rd, 32'h0000_0000, "generate reads zero");
    bus(1'b1, 8'h10, 16'h0000);
    status_is(16'h0000, "clear by zero");
    chk({31'h0, irq_req}, 0, "irq released");
    $display("test generate done");
  endtask : t_generate
  task automatic t_update();
    int d0;
    bus(1'b1, 8'h0c, 16'h0101);
    d0 = dma_total;
    ev(4'h8, 4'h0, 4'h0);
    status_is(16'h0001, "wrap flag");
    chk(dma_total - d0, 1, "wrap dma");
    bus(1'b1, 8'h10, 16'h0000);
    bus(1'b1, 8'h00, 16'h0002);
    ev(4'h8, 4'h0, 4'h0);
    status_is(16'h0000, "wrap with update disabled");
    bus(1'b1, 8'h00, 16'h0004);
    ev(4'h4, 4'h0, 4'h0);
    status_is(16'h0000, "reinit with request source set");
    bus(1'b1, 8'h00, 16'h0000);
    ev(4'h4, 4'h0, 4'h0);
    status_is(16'h0001, "slave reinit flag");
    bus(1'b1, 8'h10, 16'h0000);
    $display("test update done");
  endtask : t_update
  task automatic t_trigger();
    slave_enabled <= 1'b1;
    ev(4'h2, 4'h0, 4'h0);
    status_is(16'h0040, "trigger edge");
    bus(1'b1, 8'h10, 16'h0000);
    gated_mode <= 1'b1;
    ev(4'h2, 4'h0, 4'h0);
    status_is(16'h0000, "edge ignored in gated mode");
    ev(4'h1, 4'h0, 4'h0);
    status_is(16'h0040, "gated start stop");
    bus(1'b1, 8'h10, 16'h0000);
    $display("test trigger done");
  endtask : t_trigger
  task automatic t_capture();
    chan_is_input <= 4'h1;
    ev(4'h0, 4'h1, 4'h0);
    ev(4'h0, 4'h1, 4'h0);
    status_is(16'h0202, "overcapture ch1");
    bus(1'b1, 8'h10, 16'h1e5d);
    status_is(16'h0200, "ones keep flags");
    bus(1'b1, 8'h14, 16'h0002);
    status_is(16'h0202, "generate on input");
    chk(cap_n, 1, "capture load pulse");
    ev(4'h0, 4'h0, 4'h1);
    status_is(16'h0200, "value read clears");
    ev(4'h0, 4'h8, 4'h0);
    ev(4'h0, 4'h0, 4'h0);
    status_is(16'h0200, "output ch4 no overcapture");
    chan_is_input <= 4'h8;
    ev(4'h0, 4'h8, 4'h0);
    ev(4'h0, 4'h8, 4'h0);
    status_is(16'h1210, "overcapture ch4");
    bus(1'b1, 8'h10, 16'h0000);
    $display("test capture done");
  endtask : t_capture
  task automatic t_compare();
    chan_is_input     <= 4'h0;
    chan_above_reload <= 4'h4;
    @(posedge ref_clk);
    chan_match <= 4'h2;
    @(posedge ref_clk);
    chan_match <= 4'h0;
    ev(4'h8, 4'h0, 4'h0);
    status_is(16'h000d, "compare match and wrap above reload");
    chan_above_reload <= 4'h0;
    bus(1'b1, 8'h10, 16'h0000);
    status_is(16'h0000, "compare flags cleared");
    $display("test compare done");
  endtask : t_compare
  task automatic t_reinit();
    count_down        <= 1'b1;
    auto_reload_value <= 16'h1234;
    repeat (3) @(posedge ref_clk);
    chk({16'h0, reinit_value}, 32'h0000_1234, "down reload");
    center_aligned <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk({16'h0, reinit_value}, 32'h0000_0000, "centre reload");
    center_aligned <= 1'b0;
    count_down <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk({16'h0, reinit_value}, 32'h0000_0000, "up reload");
    $display("test reinit done");
  endtask : t_reinit
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : wrap_up
  always @(posedge ref_clk) begin
    swu_n  += {31'h0, sw_update === 1'b1};
    cap_n  += {31'h0, capture_load[0] === 1'b1};
    cycles += 1;
    if (cycles == 5000) begin
      fail_count++;
      $display("unexpected at %0t: run timed out", $time);
      wrap_up();
    end
  end
  initial begin
    {arst_n, avs_read, avs_write, avs_address, avs_writedata} = '0;
    {cnt_wrap, trig_reinit, trig_edge, gate_change, slave_enabled, gated_mode, count_down} = '0;
    {auto_reload_value, chan_is_input, chan_capture, chan_value_read} = '0;
    {center_aligned, chan_match, chan_above_reload} = '0;
    {fail_count, n_compared, cycles, swu_n, cap_n} = '0;
    repeat (8) @(posedge ref_clk);
    arst_n <= 1'b1;
    t_regs();
    t_generate();
    t_update();
    t_trigger();
    t_capture();
    t_compare();
    t_reinit();
    wrap_up();
  end
endmodule : timer_event_flags_requests_tb_top
`default_nettype wire
